// ### tsr_regs.v
// register set of the serial thermal sensor
//
// Operation
// - temperature is 8-bit two's complement, bit7 sign
// - zero degrees reads as all-zero byte
// - one count equals one degree Celsius
// - round toward minus infinity, saturate at +127
// - every visible register is eight bits
// - both registers reset zero; temperature read-only
// - new result loads when conversion-done rises
// - fixed 7-bit address within 1001xxx, default 1001101
// - done flag cleared at reset and standby
// - reading refreshes after each conversion automatically, except in standby
`timescale 1ns/10ps
`default_nettype none
`include "tsr_defs.vh"
module tsr_regs #(
	parameter [2:0] ADDR_SEL = 3'h5,
	parameter       TEMP_W   = 12
) (
	input  wire              i_mclk,
	input  wire              i_reset,
	input  wire [TEMP_W-1:0] i_conv_temp,
	input  wire              i_conv_done,
	input  wire [6:0]        i_bus_addr,
	input  wire              i_addr_valid,
	input  wire [7:0]        i_cmd,
	input  wire              i_wr,
	input  wire [7:0]        i_wdata,
	input  wire              i_rd,
	input  wire              i_rd_busy,
	output wire              o_addr_match,
	output reg  [7:0]        o_rdata,
	output wire              o_standby
);
	// converter gives signed degrees with 4 fraction bits
	reg  [7:0] temp_q;
	reg  [7:0] temp_d;
	reg  [7:0] pend_q;
	reg  [7:0] pend_d;
	reg        pend_v_q;
	reg        pend_v_d;
	reg        stby_q;
	reg        stby_d;
	reg        rdy_q;
	reg        rdy_d;
	reg        done_q;
	reg  [7:0] rdata_d;
	wire [6:0] own_addr;
	wire [7:0] cfg_rd;
	wire [7:0] new_code;
	wire       done_rise;
	wire       cfg_wr;
	wire       stby_wr;
	wire       rd_hit;

	function is_cmd;
		input [7:0] cmd;
		input [7:0] code;
		begin
			is_cmd = (cmd == code);
		end
	endfunction

	function [7:0] to_code;
		input [TEMP_W-1:0] t;
		reg   [TEMP_W-5:0] whole;
		begin
			// dropping the fraction of a signed value floors it
			whole = t[TEMP_W-1:4];
			if (!whole[TEMP_W-5] && (|whole[TEMP_W-5:7]))
				to_code = `TSR_TEMP_MAX;
			else if (whole[TEMP_W-5] && !(&whole[TEMP_W-5:7]))
				to_code = `TSR_TEMP_MIN;
			else
				to_code = whole[7:0];
		end
	endfunction

	function [7:0] rd_mux;
		input [7:0] cmd;
		input [7:0] temp;
		input [7:0] cfg;
		begin
			if (is_cmd(cmd, `TSR_CMD_TEMP))
				rd_mux = temp;
			else if (is_cmd(cmd, `TSR_CMD_CFG))
				rd_mux = cfg;
			else
				// unmapped commands read back zero
				rd_mux = `TSR_RST_VAL;
		end
	endfunction

	assign own_addr     = `TSR_ADDR_BASE | {4'h0, ADDR_SEL};
	assign o_addr_match = i_addr_valid && (i_bus_addr == own_addr);
	assign o_standby    = stby_q;
	// edges are ignored in standby so no stale result lands
	assign done_rise    = i_conv_done && !done_q && !stby_q;
	assign new_code     = to_code(i_conv_temp);
	assign cfg_wr       = i_wr && o_addr_match && is_cmd(i_cmd, `TSR_CMD_CFG);
	assign stby_wr      = cfg_wr && i_wdata[`TSR_CFG_STBY_BIT];
	assign rd_hit       = i_rd && o_addr_match;
	assign cfg_rd       = {stby_q, rdy_q, 6'h00};

	// only the standby bit is writable
	always @*
	begin
		stby_d = stby_q;
		if (cfg_wr)
			stby_d = i_wdata[`TSR_CFG_STBY_BIT];
	end

	// standby clear beats a done edge in the same cycle
	always @*
	begin
		rdy_d = rdy_q;
		if (stby_wr || stby_q)
			rdy_d = 1'b0;
		else if (done_rise)
			rdy_d = 1'b1;
	end

	// a result landing mid-read is parked until the read ends
	always @*
	begin
		temp_d   = temp_q;
		pend_d   = pend_q;
		pend_v_d = pend_v_q;
		if (done_rise && i_rd_busy)
		begin
			pend_d   = new_code;
			pend_v_d = 1'b1;
		end
		else if (done_rise)
		begin
			// newer result drops any parked one
			temp_d   = new_code;
			pend_v_d = 1'b0;
		end
		else if (pend_v_q && !i_rd_busy)
		begin
			temp_d   = pend_q;
			pend_v_d = 1'b0;
		end
	end

	always @*
	begin
		rdata_d = o_rdata;
		if (rd_hit)
			rdata_d = rd_mux(i_cmd, temp_q, cfg_rd);
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			temp_q <= `TSR_RST_VAL;
		else
			temp_q <= temp_d;
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			pend_q <= `TSR_RST_VAL;
		else
			pend_q <= pend_d;
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			pend_v_q <= 1'b0;
		else
			pend_v_q <= pend_v_d;
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			stby_q <= 1'b0;
		else
			stby_q <= stby_d;
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			rdy_q <= 1'b0;
		else
			rdy_q <= rdy_d;
	end

	// low after reset so a converter already high gives one edge
	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			done_q <= 1'b0;
		else
			done_q <= i_conv_done;
	end

	always @(posedge i_mclk or posedge i_reset)
	begin
		if (i_reset)
			o_rdata <= `TSR_RST_VAL;
		else
			o_rdata <= rdata_d;
	end

endmodule
`default_nettype wire

// ### tsr_defs.vh
// constants for the thermal sensor register set
`ifndef TSR_DEFS_VH
`define TSR_DEFS_VH
`define TSR_CMD_TEMP      8'h00
`define TSR_CMD_CFG       8'h01
`define TSR_CFG_STBY_BIT  7
`define TSR_CFG_RDY_BIT   6
`define TSR_CFG_WMASK     8'h80
`define TSR_RST_VAL       8'h00
`define TSR_TEMP_MAX      8'h7F
`define TSR_TEMP_MIN      8'h80
`define TSR_ADDR_DEFAULT  7'h4D
`define TSR_ADDR_BASE     7'h48
`endif

// ### tsr_properties.sv
// port checker
`timescale 1ns/10ps
`default_nettype none
module tsr_properties #(parameter [2:0] ADDR_SEL=3'h5,parameter TEMP_W=12)(input wire logic i_mclk,
i_reset,i_conv_done,i_addr_valid,i_wr,i_rd,i_rd_busy,o_addr_match,o_standby,input wire logic
[TEMP_W-1:0] i_conv_temp,input wire logic [6:0] i_bus_addr,input wire logic [7:0] i_cmd,i_wdata,o_rdata);
default clocking @(posedge i_mclk); endclocking
default disable iff (i_reset);
wire rd=i_rd&&o_addr_match;
wire wr=i_wr&&o_addr_match&&i_cmd==8'h01;
sequence s_done; $rose(i_conv_done)&&!o_standby&&!i_rd_busy; endsequence
AST_MATCH: assert property(o_addr_match==(i_addr_valid&&i_bus_addr=={4'h9,ADDR_SEL}))else $error("adr");
AST_WR: assert property(wr|=>o_standby==$past(i_wdata[7]))else $error("wr");
AST_KEEP: assert property(!wr|=>$stable(o_standby))else $error("keep");
AST_HOLD: assert property(!rd|=>$stable(o_rdata))else $error("hold");
AST_CFG: assert property(rd&&i_cmd==8'h01|=>o_rdata[7]==$past(o_standby)&&!o_rdata[5:0])else $error("cfg");
AST_RDY: assert property(s_done ##1 rd&&i_cmd==8'h01|=>o_rdata[6])else $error("rdy");
AST_SBY: assert property(o_standby&&rd&&i_cmd==8'h01|=>!o_rdata[6])else $error("sby");
AST_UNM: assert property(rd&&i_cmd>8'h01|=>o_rdata==8'h00)else $error("unm");
endmodule
bind tsr_regs tsr_properties #(.ADDR_SEL(ADDR_SEL),.TEMP_W(TEMP_W)) P(.*);
`default_nettype wire

// ### tsr_host.sv
// host bus model
`timescale 1ns/10ps
`default_nettype none
module tsr_host(input wire logic i_mclk,output logic i_addr_valid=0,i_rd=0,i_wr=0,i_rd_busy=0,
output logic [6:0] i_bus_addr=0,output logic [7:0] i_cmd=0,i_wdata=0);
task xf(input [6:0] a,input [7:0] c,d,input w);
@(negedge i_mclk) {i_addr_valid,i_bus_addr,i_cmd,i_wdata,i_wr,i_rd,i_rd_busy}={1'b1,a,c,d,w,!w,!w};
@(negedge i_mclk) {i_addr_valid,i_wr,i_rd,i_bus_addr,i_cmd}={3'h0,~a,~c}; // released, not held
@(negedge i_mclk) i_rd_busy=0;
endtask
endmodule
`default_nettype wire

// ### tsr_regs_tb_top.sv
// bench
`timescale 1ns/10ps
`default_nettype none
module tsr_regs_tb_top;
logic i_mclk=0,i_reset=1,i_conv_done=0,i_addr_valid,i_rd,i_wr,i_rd_busy,o_addr_match,o_standby;
logic [15:0] i_conv_temp=0;
logic [6:0] i_bus_addr;
logic [7:0] i_cmd,i_wdata,o_rdata;
int mismatches=0,checks_done=0;
always #20 i_mclk=~i_mclk;
tsr_host H(.*);
tsr_regs #(.TEMP_W(16)) DUT(.*);
task chk(input [7:0] g,e);
checks_done++;
if(g!==e) begin mismatches++; $display("BAD %0t got %h exp %h",$time,g,e); end
endtask
task rd(input [6:0] a,input [7:0] c,e);
H.xf(a,c,0,0);
chk(o_rdata,e);
endtask
task cv(input [15:0] x,input [7:0] c,e);
@(negedge i_mclk) {i_conv_temp,i_conv_done}={x,1'b1};
rd(7'h4D,c,e);
i_conv_done=0;
endtask
task report_and_stop;
if(mismatches==0&&checks_done>0) $display("All checks passed");
else $display("Checks failed");
$finish;
endtask
initial begin
repeat(3) @(negedge i_mclk);
i_reset=0;
chk({7'h00,o_standby},8'h00);
rd(7'h4D,0,0);
rd(7'h4D,1,0);
cv(0,1,8'h40);
cv(0,0,0);
cv(16'h0194,0,8'h19);
cv(16'hFFFC,0,8'hFF);
cv(16'hFE6C,0,8'hE6);
cv(16'h0820,0,8'h7F);
cv(16'hF7E0,0,8'h80);
H.xf(7'h4D,0,8'h55,1);
rd(7'h4D,0,8'h80);
rd(7'h4C,1,8'h80);
rd(7'h4D,5,0);
H.xf(7'h4D,1,8'hFF,1);
chk({7'h00,o_standby},8'h01);
rd(7'h4D,1,8'h80);
cv(16'h0190,1,8'h80);
rd(7'h4D,0,8'h80);
H.xf(7'h4C,1,0,1);
rd(7'h4D,1,8'h80);
report_and_stop;
end
endmodule
`default_nettype wire
